// *** lpd_core.sv ***
// The Avalon-MM interface to the registers and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module lpd_core (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic [2:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  output logic      [16:0] flash_addr_out,
  output logic             flash_req_out,
  output logic             flash_we_out,
  output logic      [7:0]  flash_wdata_out,
  input  wire logic        flash_ack_in,
  input  wire logic [7:0]  flash_rdata_in
);
  import lpd_pkg::*;

  lpd_state_t  state_q;
  lpd_state_t  state_d;
  logic        wait_q;
  logic        wait_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        req_q;
  logic        req_d;
  logic        we_q;
  logic        we_d;
  logic [16:0] addr_q;
  logic [16:0] addr_d;
  logic [7:0]  wdata_q;
  logic [7:0]  wdata_d;
  logic        post_q;
  logic        post_d;
  logic        pair_q;
  logic        pair_d;
  logic        sel_q;
  logic        sel_d;

  logic [16:0] ptr;
  logic        ld_hi;
  logic        ld_mid;
  logic        ld_lo;
  logic        add_go;
  logic        inc_go;
  logic        bus_req;
  logic        is_window;
  logic        is_post;

  lpd_pointer i_lpd_pointer (
    .clk_sys_in   (clk_sys_in),
    .rst_in       (rst_in),
    .load_hi_in   (ld_hi),
    .load_mid_in  (ld_mid),
    .load_lo_in   (ld_lo),
    .load_byte_in (avs_writedata_in[7:0]),
    .add_in       (add_go),
    .add_byte_in  (avs_writedata_in[7:0]),
    .inc_in       (inc_go),
    .ptr_out      (ptr)
  );

  assign bus_req   = avs_read_in || avs_write_in;
  assign is_post   = (avs_address_in == LPD_IDX_WORD) ||
                     (avs_address_in == LPD_IDX_BYTE);
  assign is_window = is_post || (avs_address_in == LPD_IDX_PLAIN);

  always_comb begin
    state_d = state_q;
    wait_d  = wait_q;
    rdata_d = rdata_q;
    req_d   = req_q;
    we_d    = we_q;
    addr_d  = addr_q;
    wdata_d = wdata_q;
    post_d  = post_q;
    pair_d  = pair_q;
    sel_d   = sel_q;
    ld_hi   = 1'b0;
    ld_mid  = 1'b0;
    ld_lo   = 1'b0;
    add_go  = 1'b0;
    inc_go  = 1'b0;
    case (state_q)
      LPD_ST_IDLE: begin
        if (bus_req && is_window) begin
          // Window access: one flash transfer per byte moved
          req_d   = 1'b1;
          we_d    = avs_write_in;
          addr_d  = ptr;
          wdata_d = avs_writedata_in[7:0];
          post_d  = is_post;
          pair_d  = (avs_address_in == LPD_IDX_WORD) &&
                    (avs_byteenable_in[1:0] == LPD_BE_PAIR);
          sel_d   = 1'b0;
          rdata_d = LPD_RDATA_RST;
          state_d = LPD_ST_MEM;
        end else if (bus_req) begin
          rdata_d = LPD_RDATA_RST;
          // Clear window flags so done-state checks see a register access
          post_d  = 1'b0;
          pair_d  = 1'b0;
          if (avs_read_in) begin
            case (avs_address_in)
              LPD_IDX_PTR_HI:  rdata_d[0] = ptr[LPD_HI_LSB];
              LPD_IDX_PTR_MID: rdata_d[7:0] = ptr[LPD_MID_LSB +: 8];
              LPD_IDX_PTR_LO:  rdata_d[7:0] = ptr[LPD_LO_LSB +: 8];
              LPD_IDX_ADD:     rdata_d[7:0] = LPD_ADD_RD_VAL;
              default:         rdata_d = LPD_RDATA_RST;
            endcase
          end else if (avs_byteenable_in[0]) begin
            ld_hi  = (avs_address_in == LPD_IDX_PTR_HI);
            ld_mid = (avs_address_in == LPD_IDX_PTR_MID);
            ld_lo  = (avs_address_in == LPD_IDX_PTR_LO);
            add_go = (avs_address_in == LPD_IDX_ADD);
          end
          wait_d  = 1'b0;
          state_d = LPD_ST_DONE;
        end
      end
      LPD_ST_MEM: begin
        if (flash_ack_in) begin
          req_d = 1'b0;
          if (!we_q) begin
            if (sel_q) begin
              rdata_d[15:8] = flash_rdata_in;
            end else begin
              rdata_d[7:0] = flash_rdata_in;
            end
          end
          // Advance only once the transfer is acknowledged
          inc_go = post_q;
          if (pair_q && !sel_q) begin
            sel_d   = 1'b1;
            state_d = LPD_ST_STEP;
          end else begin
            wait_d  = 1'b0;
            state_d = LPD_ST_DONE;
          end
        end
      end
      LPD_ST_STEP: begin
        // Second byte of a word: pointer has already moved on
        req_d   = 1'b1;
        addr_d  = ptr;
        wdata_d = avs_writedata_in[15:8];
        state_d = LPD_ST_MEM;
      end
      LPD_ST_DONE: begin
        wait_d  = 1'b1;
        state_d = LPD_ST_IDLE;
      end
      default: begin
        wait_d  = 1'b1;
        req_d   = 1'b0;
        state_d = LPD_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_q <= LPD_ST_IDLE;
      wait_q  <= 1'b1;
      rdata_q <= LPD_RDATA_RST;
      req_q   <= 1'b0;
      we_q    <= 1'b0;
      addr_q  <= LPD_PTR_RST;
      wdata_q <= 8'h00;
      post_q  <= 1'b0;
      pair_q  <= 1'b0;
      sel_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
      req_q   <= req_d;
      we_q    <= we_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
      post_q  <= post_d;
      pair_q  <= pair_d;
      sel_q   <= sel_d;
    end
  end

  assign avs_readdata_out    = rdata_q;
  assign avs_waitrequest_out = wait_q;
  assign flash_addr_out      = addr_q;
  assign flash_req_out       = req_q;
  assign flash_we_out        = we_q;
  assign flash_wdata_out     = wdata_q;

  // Helper: increments seen within the current bus transaction
  logic [1:0]  inc_cnt_q;
  logic [1:0]  inc_cnt_d;

  always_comb begin
    inc_cnt_d = inc_cnt_q;
    if (state_q == LPD_ST_IDLE) begin
      inc_cnt_d = 2'h0;
    end else if (inc_go) begin
      inc_cnt_d = inc_cnt_q + 2'h1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      inc_cnt_q <= 2'h0;
    end else begin
      inc_cnt_q <= inc_cnt_d;
    end
  end

  req_addr_ptr_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (req_q && !$past(req_q)) |-> addr_q == ptr)
    else $error("flash address differs from pointer at request");

  inc_after_ack_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (state_q == LPD_ST_MEM && req_q && !flash_ack_in) |=> ptr == $past(ptr))
    else $error("pointer moved before transfer completed");

  post_read_data_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (state_q == LPD_ST_MEM && flash_ack_in && !we_q && post_q && !sel_q)
      |=> rdata_q[7:0] == $past(flash_rdata_in) &&
          ptr == $past(ptr) + 17'h0_0001)
    else $error("post-increment read returned wrong byte or pointer");

  post_write_data_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (req_q && we_q && !sel_q) |-> flash_wdata_out == avs_writedata_in[7:0]
      && flash_we_out)
    else $error("post-increment write carried wrong byte");

  plain_keep_ptr_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (state_q == LPD_ST_MEM && flash_ack_in && !post_q) |=> ptr == $past(ptr))
    else $error("plain window access changed pointer");

  plain_write_deliver_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (state_q == LPD_ST_IDLE && avs_write_in &&
     avs_address_in == LPD_IDX_PLAIN)
      |=> flash_req_out && flash_we_out && flash_addr_out == $past(ptr))
    else $error("plain window write not delivered at pointer");

  add_byte_sum_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (state_q == LPD_ST_IDLE && avs_write_in && avs_byteenable_in[0] &&
     avs_address_in == LPD_IDX_ADD)
      |=> ptr == $past(ptr) + {{9{$past(avs_writedata_in[7])}},
                                $past(avs_writedata_in[7:0])})
    else $error("add-byte write did not add signed value");

  add_byte_zero_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (!avs_waitrequest_out && avs_read_in && avs_address_in == LPD_IDX_ADD)
      |-> avs_readdata_out == LPD_RDATA_RST)
    else $error("add-byte port did not read as zero");

  word_two_inc_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (state_q == LPD_ST_DONE && pair_q) |-> inc_cnt_q == 2'h2)
    else $error("word access did not advance pointer twice");

  hi_reads_bit_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (!avs_waitrequest_out && avs_read_in &&
     avs_address_in == LPD_IDX_PTR_HI) |-> avs_readdata_out[31:1] == 31'h0)
    else $error("pointer high byte shows bits above bit 16");

  done_one_cycle_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    !avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");

  req_hold_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (req_q && !flash_ack_in) |=> req_q && $stable(addr_q) &&
      $stable(we_q) && $stable(wdata_q))
    else $error("flash request changed before its ack");

  req_drop_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (req_q && flash_ack_in) |=> !req_q)
    else $error("flash request still up after its ack");

  plain_read_data_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (state_q == LPD_ST_MEM && flash_ack_in && !we_q && !post_q)
      |=> rdata_q[7:0] == $past(flash_rdata_in))
    else $error("plain window read returned wrong byte");

  plain_write_data_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (state_q == LPD_ST_IDLE && avs_write_in &&
     avs_address_in == LPD_IDX_PLAIN)
      |=> flash_wdata_out == $past(avs_writedata_in[7:0]))
    else $error("plain window write carried wrong byte");

  pair_second_addr_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (state_q == LPD_ST_STEP)
      |=> flash_req_out && flash_addr_out == ptr &&
          flash_wdata_out == $past(avs_writedata_in[15:8]))
    else $error("second byte of word not at advanced pointer");

  pair_high_lane_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (state_q == LPD_ST_MEM && flash_ack_in && !we_q && sel_q)
      |=> rdata_q[15:8] == $past(flash_rdata_in))
    else $error("second byte of word not in upper lane");

  byte_one_inc_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (state_q == LPD_ST_DONE && post_q && !pair_q) |-> inc_cnt_q == 2'h1)
    else $error("single byte window access did not advance once");

  plain_no_inc_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (state_q == LPD_ST_DONE && !post_q) |-> inc_cnt_q == 2'h0)
    else $error("access without post-increment advanced pointer");

  add_plus_max_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (state_q == LPD_ST_IDLE && avs_write_in && avs_byteenable_in[0] &&
     avs_address_in == LPD_IDX_ADD && avs_writedata_in[7:0] == 8'h7f)
      |=> ptr == $past(ptr) + 17'h0_007f)
    else $error("adding 0x7f did not raise the pointer by 127");

  add_minus_one_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (state_q == LPD_ST_IDLE && avs_write_in && avs_byteenable_in[0] &&
     avs_address_in == LPD_IDX_ADD && avs_writedata_in[7:0] == 8'hff)
      |=> ptr == $past(ptr) - 17'h0_0001)
    else $error("adding 0xff did not lower the pointer by 1");

  masked_write_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (state_q == LPD_ST_IDLE && avs_write_in && !avs_byteenable_in[0] &&
     !avs_address_in[2]) |=> ptr == $past(ptr))
    else $error("register write without byte enable changed pointer");

endmodule

`default_nettype wire

// *** lpd_pkg.sv ***
`default_nettype none

package lpd_pkg;

  // Pointer geometry
  localparam int          LPD_PTR_W       = 17;
  localparam logic [16:0] LPD_PTR_RST     = 17'h0_0000;
  localparam logic [16:0] LPD_PTR_STEP    = 17'h0_0001;
  localparam int          LPD_HI_LSB      = 16;
  localparam int          LPD_MID_LSB     = 8;
  localparam int          LPD_LO_LSB      = 0;

  // Register word indices on the bus (byte address is four times these)
  localparam logic [2:0]  LPD_IDX_PTR_HI  = 3'h0;
  localparam logic [2:0]  LPD_IDX_PTR_MID = 3'h1;
  localparam logic [2:0]  LPD_IDX_PTR_LO  = 3'h2;
  localparam logic [2:0]  LPD_IDX_ADD     = 3'h3;
  localparam logic [2:0]  LPD_IDX_PLAIN   = 3'h4;
  localparam logic [2:0]  LPD_IDX_WORD    = 3'h5;
  localparam logic [2:0]  LPD_IDX_BYTE    = 3'h6;

  // Bus-side reset value, add-port read value and word byte-enable pattern
  localparam logic [31:0] LPD_RDATA_RST   = 32'h0000_0000;
  localparam logic [7:0]  LPD_ADD_RD_VAL  = 8'h00;
  localparam logic [1:0]  LPD_BE_PAIR     = 2'h3;

  typedef enum logic [1:0] {
    LPD_ST_IDLE = 2'b00,
    LPD_ST_MEM  = 2'b01,
    LPD_ST_STEP = 2'b11,
    LPD_ST_DONE = 2'b10
  } lpd_state_t;

endpackage

`default_nettype wire

// *** lpd_pointer.sv ***
`timescale 1ns/10ps
`default_nettype none

module lpd_pointer (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic        load_hi_in,
  input  wire logic        load_mid_in,
  input  wire logic        load_lo_in,
  input  wire logic [7:0]  load_byte_in,
  input  wire logic        add_in,
  input  wire logic [7:0]  add_byte_in,
  input  wire logic        inc_in,
  output logic      [16:0] ptr_out
);
  import lpd_pkg::*;

  logic [16:0] ptr_q;
  logic [16:0] ptr_d;
  logic [16:0] add_ext;

  // Sign extension lets one adder serve both directions
  assign add_ext = {{9{add_byte_in[7]}}, add_byte_in};

  always_comb begin
    ptr_d = ptr_q;
    if (load_hi_in) begin
      ptr_d[LPD_HI_LSB] = load_byte_in[0];
    end
    if (load_mid_in) begin
      ptr_d[LPD_MID_LSB +: 8] = load_byte_in;
    end
    if (load_lo_in) begin
      ptr_d[LPD_LO_LSB +: 8] = load_byte_in;
    end
    if (add_in) begin
      ptr_d = ptr_q + add_ext;
    end
    if (inc_in) begin
      ptr_d = ptr_q + LPD_PTR_STEP;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ptr_q <= LPD_PTR_RST;
    end else begin
      ptr_q <= ptr_d;
    end
  end

  assign ptr_out = ptr_q;

  wrap_inc_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (inc_in && ptr_q == 17'h1_ffff) |=> ptr_q == 17'h0_0000)
    else $error("pointer increment did not wrap to zero");

  add_sign_a: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (add_in && !inc_in && add_byte_in == 8'h80)
      |=> ptr_q == $past(ptr_q) - 17'h0_0080)
    else $error("adding 0x80 did not lower the pointer by 128");

endmodule

`default_nettype wire

// *** lpd_flash_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module lpd_flash_model (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic [16:0] addr_in,
  input  wire logic        req_in,
  input  wire logic        we_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic [3:0]  delay_in,
  output logic             ack_out,
  output logic      [7:0]  rdata_out
);
  logic [7:0] mem [0:131071];
  logic [3:0] wait_q;

  // Unwritten bytes read a pattern derived from their address
  initial begin
    for (int i = 0; i < 131072; i++) begin
      mem[i] = i[7:0] ^ i[15:8] ^ {7'h00, i[16]};
    end
    ack_out = 1'b0;
    rdata_out = 8'h00;
    wait_q = 4'h0;
  end

  always @(posedge clk_sys_in) begin
    ack_out <= 1'b0;
    // Read data is only good in the ack cycle, so scramble it otherwise
    rdata_out <= ~rdata_out;
    if (rst_in) begin
      wait_q <= 4'h0;
    end else if (req_in && !ack_out) begin
      if (wait_q == delay_in) begin
        ack_out <= 1'b1;
        wait_q <= 4'h0;
        if (we_in) begin
          mem[addr_in] <= wdata_in;
        end else begin
          rdata_out <= mem[addr_in];
        end
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule

`default_nettype wire

// *** lpd_core_test.sv ***
`timescale 1ns/10ps
`default_nettype none

module lpd_core_test;
  import lpd_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [2:0]  avs_address_in = 3'h0;
  logic        avs_read_in = 1'b0;
  logic        avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [3:0]  avs_byteenable_in = 4'h0;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  logic [16:0] flash_addr_out;
  logic        flash_req_out;
  logic        flash_we_out;
  logic [7:0]  flash_wdata_out;
  logic        flash_ack;
  logic [7:0]  flash_rdata;
  logic [3:0]  flash_delay = 4'h0;
  int          n_mismatch = 0;
  int          comparisons = 0;

  always #10 clk_sys_in = ~clk_sys_in;

  lpd_core i_lpd_core (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .flash_addr_out(flash_addr_out), .flash_req_out(flash_req_out),
    .flash_we_out(flash_we_out), .flash_wdata_out(flash_wdata_out),
    .flash_ack_in(flash_ack), .flash_rdata_in(flash_rdata)
  );

  lpd_flash_model i_lpd_flash_model (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .addr_in(flash_addr_out),
    .req_in(flash_req_out), .we_in(flash_we_out),
    .wdata_in(flash_wdata_out), .delay_in(flash_delay),
    .ack_out(flash_ack), .rdata_out(flash_rdata)
  );

  function automatic logic [7:0] pat(input logic [16:0] a);
    return a[7:0] ^ a[15:8] ^ {7'h00, a[16]};
  endfunction

  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Request stays up until the edge that samples waitrequest low
  task automatic acc(input logic w, input logic [2:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    avs_address_in <= a;
    avs_write_in <= w;
    avs_read_in <= !w;
    avs_writedata_in <= d;
    avs_byteenable_in <= be;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 400);
    if (n >= 400) begin
      n_mismatch++;
      end_of_test();
    end else begin
      q = avs_readdata_out;
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
      @(posedge clk_sys_in);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, 4'h1, q);
  endtask

  task automatic rd(input logic [2:0] a, output logic [31:0] q);
    acc(1'b0, a, 32'h0, 4'h1, q);
  endtask

  task automatic set_ptr(input logic [16:0] p);
    wr(LPD_IDX_PTR_HI, {31'h0, p[16]});
    wr(LPD_IDX_PTR_MID, {24'h0, p[15:8]});
    wr(LPD_IDX_PTR_LO, {24'h0, p[7:0]});
  endtask

  task automatic chk_ptr(input logic [16:0] p);
    logic [31:0] q;
    rd(LPD_IDX_PTR_HI, q);
    chk(q, {31'h0, p[16]});
    rd(LPD_IDX_PTR_MID, q);
    chk(q, {24'h0, p[15:8]});
    rd(LPD_IDX_PTR_LO, q);
    chk(q, {24'h0, p[7:0]});
  endtask

  initial begin
    logic [31:0] q;
    logic [16:0] p;
    logic [7:0]  adds [3];
    adds = '{8'h7f, 8'hff, 8'h80};
    repeat (12) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    chk_ptr(17'h0_0000);
    rd(LPD_IDX_ADD, q);
    chk(q, 32'h0);
    rd(3'h7, q);
    chk(q, 32'h0);
    acc(1'b1, LPD_IDX_PTR_LO, 32'h55, 4'h0, q);
    chk_ptr(17'h0_0000);
    set_ptr(17'h1_00fe);
    chk_ptr(17'h1_00fe);
    rd(LPD_IDX_PLAIN, q);
    chk(q, {24'h0, pat(17'h1_00fe)});
    wr(LPD_IDX_PLAIN, 32'ha5);
    chk({24'h0, i_lpd_flash_model.mem[17'h1_00fe]}, 32'ha5);
    chk_ptr(17'h1_00fe);
    // Slow flash so the pointer step must wait for the ack
    flash_delay <= 4'h5;
    rd(LPD_IDX_BYTE, q);
    chk(q, 32'ha5);
    chk_ptr(17'h1_00ff);
    rd(LPD_IDX_WORD, q);
    chk(q, {24'h0, pat(17'h1_00ff)});
    chk_ptr(17'h1_0100);
    acc(1'b1, LPD_IDX_WORD, 32'hc33c, 4'h3, q);
    chk({24'h0, i_lpd_flash_model.mem[17'h1_0100]}, 32'h3c);
    chk({24'h0, i_lpd_flash_model.mem[17'h1_0101]}, 32'hc3);
    chk_ptr(17'h1_0102);
    flash_delay <= 4'h0;
    set_ptr(17'h1_0100);
    acc(1'b0, LPD_IDX_WORD, 32'h0, 4'h3, q);
    chk(q, 32'hc33c);
    chk_ptr(17'h1_0102);
    set_ptr(17'h1_ffff);
    wr(LPD_IDX_BYTE, 32'h69);
    chk({24'h0, i_lpd_flash_model.mem[17'h1_ffff]}, 32'h69);
    chk_ptr(17'h0_0000);
    p = 17'h0_0000;
    foreach (adds[i]) begin
      wr(LPD_IDX_ADD, {24'h0, adds[i]});
      p = p + {{9{adds[i][7]}}, adds[i]};
      chk_ptr(p);
    end
    // Reset in mid-run must bring the pointer back to zero
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    chk_ptr(17'h0_0000);
    end_of_test();
  end
endmodule

`default_nettype wire
